// File: core/meti_core.v
// Purpose: Motion generator two (threshold, duration, latch) and tap event
//          capture with their registers on the serial register port.
// Assumes: Register strobes and sample inputs are synchronous to core_clk_i.
//          sample_valid_i pulses once per output sample; tap_event_i comes
//          from the tap recogniser and is read on that same pulse.
// Notes: One duration count is one output sample period.
// Operation
// R1: Read-only generator two source register
// R2: Axis flags set on event, reset zero
// R3: Source read clears flags and interrupt
// R4: Seven-bit motion threshold, resets zero
// R5: Threshold MSB selects counter reset/decrement
// R6: Eight-bit duration, event must persist
// R7: 400 Hz: 2.5 ms per count
// R8: 100 Hz: 10 ms per count
// R9: Latched and event: counter holds
// R10: Tap latch bit, read refreshes source; the code clears the tap source on a read
// R11: Six tap enables, Z to X
// R12: Per axis double/single enables select output
// R13: Tap source: active plus six flags
// R14: Y and X tap thresholds share register
// R15: Z tap threshold in low nibble
// R16: Tap threshold 0.5 g per code
// R17: Generator two latch bit
// R18: Combine enabled events by OR/AND
// R19: High above, low below threshold enables
// R20: Unlatched flags follow each new sample
// R21: Unused bits read zero, ignore writes
`timescale 1ns/100ps
`include "meti_defs.vh"

module meti_core (
   input wire core_clk_i,               // 200 MHz core clock
   input wire rstn_i,                   // Asynchronous reset, active low
   input wire ce_i,                     // Clock enable, freezes state when low
   input wire [7:0] reg_addr_i,         // Register address
   input wire reg_wr_i,                 // Write strobe, one cycle
   input wire reg_rd_i,                 // Read strobe, one cycle
   input wire [7:0] reg_wdata_i,        // Write data
   output wire [7:0] reg_rdata_o,       // Read data, valid cycle after strobe
   input wire output_sample_rate_i,     // 1 = 400 Hz, 0 = 100 Hz
   input wire sample_valid_i,           // New acceleration sample pulse
   input wire [7:0] accel_x_i,          // X sample, two's complement
   input wire [7:0] accel_y_i,          // Y sample, two's complement
   input wire [7:0] accel_z_i,          // Z sample, two's complement
   input wire [5:0] tap_event_i,        // dZ sZ dY sY dX sX tap detections
   output wire motion_gen2_irq_o,       // Generator two interrupt, level
   output wire tap_irq_o,               // Tap interrupt, level
   output wire [12:0] x_tap_level_mg_o, // X tap threshold in milli-g
   output wire [12:0] y_tap_level_mg_o, // Y tap threshold in milli-g
   output wire [12:0] z_tap_level_mg_o, // Z tap threshold in milli-g
   output wire [15:0] step_time_us_o    // Duration step in microseconds
);

   reg rst_meta_ff;
   reg rst_sync_ff;
   reg [7:0] cfg2_ff;
   reg [6:0] src2_ff;
   reg [7:0] ths2_ff;
   reg [7:0] dur2_ff;
   reg [7:0] cnt_ff;
   reg [6:0] tcfg_ff;
   reg [6:0] tsrc_ff;
   reg [7:0] ttyx_ff;
   reg [3:0] ttz_ff;
   reg [7:0] rdata_ff;
   reg [12:0] xmg_ff;
   reg [12:0] ymg_ff;
   reg [12:0] zmg_ff;
   reg [15:0] step_ff;
   reg [7:0] nxt_cnt;
   reg [6:0] nxt_src2;
   reg [6:0] nxt_tsrc;
   reg [7:0] nxt_rdata;

   wire rst_n = rst_sync_ff;

   // Magnitude of a two's complement sample; -128 saturates to 127
   function [6:0] mag7;
      input [7:0] s;
      reg [7:0] a;
      begin
         a = s[7] ? (~s + 8'h01) : s;
         mag7 = a[7] ? 7'h7f : a[6:0];
      end
   endfunction

   // Tap threshold code to milli-g
   function [12:0] tap_mg;
      input [3:0] code;
      reg [31:0] prod;
      begin
         prod = code * `METI_TAP_STEP_MG;
         // Largest code gives 7500, so the upper bits are always zero
         tap_mg = prod[12:0]; // [R16]
      end
   endfunction

   always @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   wire [6:0] ths = ths2_ff[6:0]; // [R4]
   wire [6:0] mx = mag7(accel_x_i);
   wire [6:0] my = mag7(accel_y_i);
   wire [6:0] mz = mag7(accel_z_i);
   // Raw conditions in source layout: zh zl yh yl xh xl
   wire [5:0] raw = {mz > ths, mz < ths, my > ths, my < ths, mx > ths, mx < ths}; // [R19]
   wire [5:0] en2 = cfg2_ff[5:0];
   wire [5:0] hit2 = raw & en2;
   wire comb = cfg2_ff[`METI_CFG_COMBINE];
   // AND needs every enabled event; with nothing enabled nothing fires
   wire cond = comb ? ((&(hit2 | ~en2)) & (|en2)) : (|hit2); // [R18]
   wire latch2 = cfg2_ff[`METI_CFG_LATCH]; // [R17]
   wire hold2 = latch2 & src2_ff[`METI_SRC_ACTIVE];
   wire fire = cond & (nxt_cnt >= dur2_ff); // [R6]

   wire rd_src2 = reg_rd_i & (reg_addr_i == `METI_ADDR_SRC2);
   wire rd_tsrc = reg_rd_i & (reg_addr_i == `METI_ADDR_TSRC);
   wire [5:0] tap_hit = tap_event_i & tcfg_ff[5:0]; // [R11] [R12]

   always @*
   begin
      nxt_cnt = cnt_ff;
      if (sample_valid_i)
      begin
         if (cond)
         begin
            if (!(hold2) && cnt_ff != 8'hff) // [R9]
               nxt_cnt = cnt_ff + 8'h01;
         end
         else if (ths2_ff[`METI_THS_MODE]) // [R5]
            nxt_cnt = (cnt_ff != 8'h00) ? cnt_ff - 8'h01 : 8'h00;
         else
            nxt_cnt = 8'h00;
      end
   end

   always @*
   begin
      nxt_src2 = src2_ff;
      if (rd_src2)
         nxt_src2 = 7'h00; // [R3]
      if (sample_valid_i)
      begin
         if (latch2)
         begin
            // A new event wins over a read in the same cycle
            if (fire)
               nxt_src2 = nxt_src2 | {1'b1, hit2}; // [R2]
         end
         else
            // Axis flags track every sample; only the active bit waits for the duration
            nxt_src2 = {fire, hit2}; // [R20]
      end
   end

   always @*
   begin
      nxt_tsrc = tsrc_ff;
      if (rd_tsrc)
         nxt_tsrc = 7'h00; // [R10]
      if (sample_valid_i)
      begin
         if (tcfg_ff[`METI_TCFG_LATCH])
            nxt_tsrc = nxt_tsrc | {|tap_hit, tap_hit}; // [R13]
         else
            nxt_tsrc = {|tap_hit, tap_hit};
      end
   end

   always @*
   begin
      case (reg_addr_i)
         `METI_ADDR_CFG2: nxt_rdata = cfg2_ff;
         `METI_ADDR_SRC2: nxt_rdata = {1'b0, src2_ff}; // [R1]
         `METI_ADDR_THS2: nxt_rdata = ths2_ff;
         `METI_ADDR_DUR2: nxt_rdata = dur2_ff;
         `METI_ADDR_TCFG: nxt_rdata = {1'b0, tcfg_ff}; // [R21]
         `METI_ADDR_TSRC: nxt_rdata = {1'b0, tsrc_ff}; // [R21]
         `METI_ADDR_TTYX: nxt_rdata = ttyx_ff; // [R14]
         `METI_ADDR_TTZ: nxt_rdata = {4'h0, ttz_ff}; // [R15]
         default: nxt_rdata = 8'h00;
      endcase
   end

   always @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg2_ff <= `METI_RST_CFG2;
         src2_ff <= 7'h00;
         ths2_ff <= `METI_RST_THS2;
         dur2_ff <= `METI_RST_DUR2;
         cnt_ff <= 8'h00;
         tcfg_ff <= `METI_RST_TCFG;
         tsrc_ff <= 7'h00;
         ttyx_ff <= `METI_RST_TTYX;
         ttz_ff <= `METI_RST_TTZ;
         rdata_ff <= 8'h00;
         xmg_ff <= 13'h0000;
         ymg_ff <= 13'h0000;
         zmg_ff <= 13'h0000;
         step_ff <= 16'h0000;
      end
      else if (ce_i)
      begin
         cnt_ff <= nxt_cnt;
         src2_ff <= nxt_src2;
         tsrc_ff <= nxt_tsrc;
         if (reg_rd_i)
            rdata_ff <= nxt_rdata;
         if (reg_wr_i)
         begin
            case (reg_addr_i)
               `METI_ADDR_CFG2: cfg2_ff <= reg_wdata_i;
               `METI_ADDR_THS2: ths2_ff <= reg_wdata_i;
               `METI_ADDR_DUR2: dur2_ff <= reg_wdata_i;
               `METI_ADDR_TCFG: tcfg_ff <= reg_wdata_i[6:0]; // [R21]
               `METI_ADDR_TTYX: ttyx_ff <= reg_wdata_i;
               `METI_ADDR_TTZ: ttz_ff <= reg_wdata_i[3:0]; // [R21]
               default: ;
            endcase
         end
         xmg_ff <= tap_mg(ttyx_ff[3:0]);
         ymg_ff <= tap_mg(ttyx_ff[7:4]);
         zmg_ff <= tap_mg(ttz_ff);
         // Count length follows the sample period, so only the step changes
         step_ff <= output_sample_rate_i ? 16'd`METI_STEP_400HZ_US   // [R7]
                                         : 16'd`METI_STEP_100HZ_US;  // [R8]
      end
   end

   assign reg_rdata_o = rdata_ff;
   assign motion_gen2_irq_o = src2_ff[`METI_SRC_ACTIVE]; // [R3]
   assign tap_irq_o = tsrc_ff[`METI_SRC_ACTIVE];
   assign x_tap_level_mg_o = xmg_ff;
   assign y_tap_level_mg_o = ymg_ff;
   assign z_tap_level_mg_o = zmg_ff;
   assign step_time_us_o = step_ff;

endmodule

// File: core/meti_defs.vh
// Purpose: Constants for the motion generator two and tap event block
// Assumes: Included by meti_core.v only
// Notes: Offsets are the byte addresses of the serial register port
`ifndef METI_DEFS_VH
`define METI_DEFS_VH

`define METI_ADDR_CFG2 8'h34
`define METI_ADDR_SRC2 8'h35
`define METI_ADDR_THS2 8'h36
`define METI_ADDR_DUR2 8'h37
`define METI_ADDR_TCFG 8'h38
`define METI_ADDR_TSRC 8'h39
`define METI_ADDR_TTYX 8'h3b
`define METI_ADDR_TTZ 8'h3c

`define METI_RST_CFG2 8'h00
`define METI_RST_THS2 8'h00
`define METI_RST_DUR2 8'h00
`define METI_RST_TCFG 7'h00
`define METI_RST_TTYX 8'h00
`define METI_RST_TTZ 4'h0

// Field positions
`define METI_CFG_COMBINE 7
`define METI_CFG_LATCH 6
`define METI_THS_MODE 7
`define METI_TCFG_LATCH 6
`define METI_SRC_ACTIVE 6

// Duration step per sample, in microseconds, and sample rate, in hertz, for each rate
`define METI_STEP_400HZ_US 2500
`define METI_STEP_100HZ_US 10000
`define METI_RATE_400HZ_HZ 400
`define METI_RATE_100HZ_HZ 100
// Tap threshold step in milli-g
`define METI_TAP_STEP_MG 500

`endif

// File: testbench/meti_chk.sv
// Purpose: Port checker for the motion and tap event core
// Assumes: Bound to meti_core from the bench top
// Notes: Quiet until the two-flop reset release has settled
`timescale 1ns/100ps
module meti_chk (
   input wire core_clk_i, // Clock
   input wire rstn_i, // Reset
   input wire ce_i, // Enable
   input wire [7:0] reg_addr_i, // Address
   input wire reg_wr_i, // Write
   input wire reg_rd_i, // Read
   input wire [7:0] reg_wdata_i, // Write data
   input wire [7:0] reg_rdata_o, // Read data
   input wire output_sample_rate_i, // Rate
   input wire sample_valid_i, // Sample
   input wire [5:0] tap_event_i, // Taps
   input wire motion_gen2_irq_o, // Motion irq
   input wire tap_irq_o, // Tap irq
   input wire [12:0] x_tap_level_mg_o, // X level
   input wire [12:0] y_tap_level_mg_o, // Y level
   input wire [12:0] z_tap_level_mg_o, // Z level
   input wire [15:0] step_time_us_o // Step
);
   reg [1:0] up_ff;
   wire rd_go = ce_i && reg_rd_i;
   wire wr_go = ce_i && reg_wr_i;
   wire smp = ce_i && sample_valid_i;
   // Strobes are not taken before the third edge after release
   always @(posedge core_clk_i or negedge rstn_i)
      if (!rstn_i)
         up_ff <= 2'h0;
      else if (up_ff != 2'h3)
         up_ff <= up_ff + 2'h1;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (up_ff != 2'h3);
   a_gen_read_clear: assert property (rd_go && reg_addr_i == 8'h35 && !sample_valid_i
      |=> !motion_gen2_irq_o) else $error("motion irq not cleared by read");
   a_tap_read_clear: assert property (rd_go && reg_addr_i == 8'h39 && !sample_valid_i
      |=> !tap_irq_o) else $error("tap irq not cleared by read");
   a_gen_rise_cause: assert property ($rose(motion_gen2_irq_o) |-> $past(smp))
      else $error("motion irq rose without a sample");
   a_gen_fall_cause: assert property ($fell(motion_gen2_irq_o)
      |-> $past(smp || rd_go && reg_addr_i == 8'h35)) else $error("motion irq fell alone");
   a_tap_rise_cause: assert property ($rose(tap_irq_o) |-> $past(smp && |tap_event_i))
      else $error("tap irq rose without a tap");
   a_rdata_hold: assert property (!rd_go |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   a_step_time: assert property (ce_i |=> step_time_us_o ==
      ($past(output_sample_rate_i) ? 16'd2500 : 16'd10000)) else $error("bad step time");
   a_z_level: assert property (wr_go && reg_addr_i == 8'h3c |=> ##1
      z_tap_level_mg_o == $past(reg_wdata_i[3:0], 2) * 13'd500) else $error("bad z level");
   a_yx_level: assert property (wr_go && reg_addr_i == 8'h3b |=> ##1
      x_tap_level_mg_o == $past(reg_wdata_i[3:0], 2) * 13'd500 &&
      y_tap_level_mg_o == $past(reg_wdata_i[7:4], 2) * 13'd500) else $error("bad yx level");
endmodule

// File: testbench/meti_host.sv
// Purpose: Host model issuing register reads and writes
// Assumes: One strobe per transfer, taken at the next rising edge
// Notes: Write data is inverted once released so stale values never match
`timescale 1ns/100ps
module meti_host (
   input wire core_clk_i, // Clock
   input wire [7:0] rdata_i, // Read data
   output reg [7:0] addr_o = 8'h00, // Address
   output reg wr_o = 1'b0, // Write strobe
   output reg rd_o = 1'b0, // Read strobe
   output reg [7:0] wdata_o = 8'h00 // Write data
);
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge core_clk_i);
         addr_o <= a;
         wdata_o <= d;
         wr_o <= 1'b1;
         @(posedge core_clk_i);
         wr_o <= 1'b0;
         wdata_o <= ~d;
      end
   endtask
   task rd(input [7:0] a, output [7:0] d);
      begin
         @(posedge core_clk_i);
         addr_o <= a;
         rd_o <= 1'b1;
         @(posedge core_clk_i);
         rd_o <= 1'b0;
         @(negedge core_clk_i);
         d = rdata_i;
      end
   endtask
endmodule

// File: testbench/motion_event_irq_and_tap_detect_bench.sv
// Purpose: Self-checking bench for the motion and tap event core
// Assumes: Host model drives the register port
// Notes: Random stimulus from a fixed seed plus corner cases
`timescale 1ns/100ps
module motion_event_irq_and_tap_detect_bench;
   reg core_clk_i = 1'b0;
   reg rstn_i = 1'b0;
   reg rate = 1'b1;
   reg sv = 1'b0;
   reg [23:0] acc = 24'h0;
   reg [5:0] tev = 6'h0;
   wire [7:0] addr, wdata, rdata;
   wire wr, rd, girq, tirq;
   wire [15:0] step;
   integer errors = 0, compares = 0, i, k;
   reg [7:0] r, c, t, e;
   reg [23:0] a;
   always #2.5 core_clk_i = ~core_clk_i;
   meti_host i_host (.core_clk_i(core_clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
      .rd_o(rd), .wdata_o(wdata));
   meti_core i_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .reg_addr_i(addr),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .output_sample_rate_i(rate), .sample_valid_i(sv), .accel_x_i(acc[7:0]),
      .accel_y_i(acc[15:8]), .accel_z_i(acc[23:16]), .tap_event_i(tev),
      .motion_gen2_irq_o(girq), .tap_irq_o(tirq), .x_tap_level_mg_o(), .y_tap_level_mg_o(),
      .z_tap_level_mg_o(), .step_time_us_o(step));
   task chk(input [7:0] got, input [7:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp)
         begin
            errors = errors + 1;
            $display("Error %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task rchk(input [7:0] ad, input [7:0] exp);
      begin
         i_host.rd(ad, r);
         chk(r, exp);
      end
   endtask
   task smp(input [23:0] s, input [5:0] tp);
      begin
         @(posedge core_clk_i);
         acc <= s;
         tev <= tp;
         sv <= 1'b1;
         @(posedge core_clk_i);
         sv <= 1'b0;
         @(negedge core_clk_i);
      end
   endtask
   // Magnitude saturates at 127 so -128 still compares in range
   function [6:0] mag(input [7:0] v);
      mag = v[7] ? ((v == 8'h80) ? 7'h7f : 7'd0 - v[6:0]) : v[6:0];
   endfunction
   function [7:0] gexp(input [7:0] cf, input [6:0] th, input [23:0] s);
      reg [5:0] f;
      integer j;
      begin
         for (j = 0; j < 3; j = j + 1)
         begin
            f[2*j+1] = mag(s[8*j+:8]) > th;
            f[2*j] = mag(s[8*j+:8]) < th;
         end
         f = f & cf[5:0];
         gexp = {1'b0, cf[7] ? (f == cf[5:0] && f != 6'h0) : |f, f};
      end
   endfunction
   task stop_test;
      begin
         $display("Compares %0d errors %0d", compares, errors);
         if (errors == 0 && compares > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   initial
   begin
      repeat (20000) @(posedge core_clk_i);
      errors = errors + 1;
      stop_test;
   end
   initial
   begin
      e = $urandom(32'h0179);
      repeat (3) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      for (i = 8'h34; i <= 8'h3c; i = i + 1)
         rchk(i[7:0], 8'h00);
      for (i = 0; i < 8; i = i + 1)
      begin
         c = $urandom;
         k = 8'h36 + i;
         i_host.wr(k[7:0], c);
         rchk(k[7:0], (i < 2 || i == 5) ? c : i == 2 ? c & 8'h7f : i == 6 ? c & 8'h0f : 8'h00);
      end
      i_host.wr(8'h37, 8'h00);
      for (i = 0; i < 24; i = i + 1)
      begin
         c = $urandom & 8'hbf;
         t = (i == 1) ? 8'h00 : $urandom;
         a = (i == 0) ? 24'h807f00 : $urandom;
         i_host.wr(8'h34, c);
         i_host.wr(8'h36, t);
         smp(a, 6'h0);
         rchk(8'h35, gexp(c, t[6:0], a));
      end
      for (i = 0; i < 2; i = i + 1)
      begin
         i_host.wr(8'h34, 8'h02);
         i_host.wr(8'h36, 8'h10);
         smp(24'h0, 6'h0);
         i_host.wr(8'h36, {i[0], 7'h10});
         i_host.wr(8'h37, 8'h03);
         for (k = 0; k < 5; k = k + 1)
            smp((k == 2) ? 24'h0 : 24'h40, 6'h0);
         chk({7'h0, girq}, {7'h0, i[0]});
         i_host.rd(8'h35, r);
         chk({7'h0, girq}, 8'h00);
      end
      i_host.wr(8'h34, 8'h42);
      i_host.wr(8'h37, 8'h00);
      smp(24'h40, 6'h0);
      smp(24'h0, 6'h0);
      rchk(8'h35, 8'h42);
      rchk(8'h35, 8'h00);
      for (i = 0; i < 12; i = i + 1)
      begin
         c = (i == 0) ? 8'h3f : $urandom & 8'hbf;
         e = (i == 0) ? 8'h3f : $urandom;
         i_host.wr(8'h38, c);
         rchk(8'h38, c & 8'h7f);
         smp(24'h0, e[5:0]);
         e = e & c & 8'h3f;
         rchk(8'h39, {1'b0, |e, e[5:0]});
      end
      i_host.wr(8'h38, 8'h7f);
      smp(24'h0, 6'h01);
      smp(24'h0, 6'h04);
      smp(24'h0, 6'h00);
      chk({7'h0, tirq}, 8'h01);
      rchk(8'h39, 8'h45);
      chk({7'h0, tirq}, 8'h00);
      rchk(8'h39, 8'h00);
      @(posedge core_clk_i);
      rate <= 1'b0;
      repeat (2) @(negedge core_clk_i);
      chk(step[15:8], 8'h27);
      chk(step[7:0], 8'h10);
      stop_test;
   end
endmodule
bind meti_core meti_chk i_chk (.core_clk_i, .rstn_i, .ce_i, .reg_addr_i, .reg_wr_i,
   .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .output_sample_rate_i, .sample_valid_i,
   .tap_event_i, .motion_gen2_irq_o, .tap_irq_o, .x_tap_level_mg_o, .y_tap_level_mg_o,
   .z_tap_level_mg_o, .step_time_us_o);
